// [logic/serial_fram_pkg.sv]
// Constants and types shared by the serial F-RAM slave port and its array.
// Assumes a single SPI master drives the pins in clock mode zero or three.
package serial_fram_pkg;

  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 8;
  localparam int MEM_DEPTH = 65536;

  // Command codes
  localparam logic [7:0] OPC_WR_ENABLE  = 8'h06;
  localparam logic [7:0] OPC_WR_DISABLE = 8'h04;
  localparam logic [7:0] OPC_STAT_RD    = 8'h05;
  localparam logic [7:0] OPC_STAT_WR    = 8'h01;
  localparam logic [7:0] OPC_READ       = 8'h03;
  localparam logic [7:0] OPC_WRITE      = 8'h02;
  localparam logic [7:0] OPC_ID_RD      = 8'h9F;

  // Status byte layout
  localparam int SR_PPE_BIT = 7;
  localparam int SR_BP_HI   = 3;
  localparam int SR_BP_LO   = 2;
  localparam int SR_WEL_BIT = 1;
  localparam logic [7:0] SR_RESET = 8'h00;

  // Block protect codes
  localparam logic [1:0] BP_NONE    = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF    = 2'h2;
  localparam logic [1:0] BP_ALL     = 2'h3;

  // Identification bytes, values arbitrary
  localparam logic [7:0] ID_MAKER    = 8'h5A;
  localparam logic [7:0] ID_DENSITY  = 8'h21;
  localparam logic [7:0] ID_REVISION = 8'h01;

  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [7:0] {
    ST_OPCODE  = 8'h01,
    ST_ADDR    = 8'h02,
    ST_WRITE   = 8'h04,
    ST_READ    = 8'h08,
    ST_STAT_RD = 8'h10,
    ST_STAT_WR = 8'h20,
    ST_ID      = 8'h40,
    ST_IGNORE  = 8'h80
  } link_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } write_word_type;

endpackage

// [logic/fram_array.sv]
// Byte-wide storage array of the F-RAM port, one access per clock edge.
// Assumes reads and writes never fall on the same edge.
`timescale 1ns/1ps
module fram_array (
  input  wire logic                                clk,
  input  wire logic                                we,
  input  wire logic                                re,
  input  wire logic [serial_fram_pkg::ADDR_W-1:0]  addr,
  input  wire logic [serial_fram_pkg::DATA_W-1:0]  wdata,
  output logic      [serial_fram_pkg::DATA_W-1:0]  rdata
);
  import serial_fram_pkg::*;

  logic [DATA_W-1:0] mem [MEM_DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // Registered read so the byte is ready before the next falling edge
  always_ff @(posedge clk) begin
    if (re) begin
      rdata <= mem[addr];
    end
  end

endmodule

// [logic/serial_fram_port.sv]
// SPI slave port of a 64K x 8 serial F-RAM with a committed-write stream.
// Assumes SCK, SI, HOLD_N come from the master; CORE_CLK is unrelated.
`timescale 1ns/1ps
module serial_fram_port (
  input  wire logic                            CORE_CLK,
  input  wire logic                            RESET_N,
  input  wire logic                            SCK,
  input  wire logic                            CS_N,
  input  wire logic                            SI,
  output logic                                 SO,
  output logic                                 SO_OE_N,
  input  wire logic                            WP_N,
  input  wire logic                            HOLD_N,
  output serial_fram_pkg::write_word_type      WR_WORD,
  output logic                                 WR_VALID,
  input  wire logic                            WR_READY,
  output logic                                 OVERRUN,
  output logic                                 STANDBY,
  output logic                                 LINK_MODE3
);
  import serial_fram_pkg::*;

  // Link side, clocked by SCK
  link_state_type    state_reg;
  logic [2:0]        bit_cnt_reg;
  logic [6:0]        shift_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              addr_byte_reg;
  logic              read_cmd_reg;
  logic              rose_reg;
  logic              mode3_reg;
  logic              so_reg;
  logic              oe_n_reg;
  logic [6:0]        tx_shift_reg;
  logic              wel_reg;
  logic [1:0]        bp_reg;
  logic              ppe_reg;
  logic              wp_meta_reg;
  logic              wp_sync_reg;
  logic              req_reg;
  write_word_type    xfer_reg;
  logic              ovr_reg;
  logic              ack_meta_reg;
  logic              ack_sync_reg;

  // Core side
  logic              req_meta_reg;
  logic              req_sync_reg;
  logic              ack_reg;
  logic              ovr_meta_reg;
  logic              ovr_sync_reg;
  logic              mode_meta_reg;
  logic              mode_sync_reg;
  logic              cs_meta_reg;
  logic              cs_sync_reg;
  write_word_type    out_reg;
  logic              out_valid_reg;
  write_word_type    spare_reg;
  logic              spare_valid_reg;

  logic              link_rst;
  logic              byte_done;
  logic [7:0]        rx_byte;
  logic [7:0]        status_byte;
  logic [7:0]        tx_byte;
  logic [7:0]        mem_rdata;
  logic [ADDR_W-1:0] mem_addr;
  logic              mem_re;
  logic              wr_commit;
  logic              sr_commit;
  logic              tx_state;
  logic              push;
  logic              pop;
  logic              buf_ready;

  // Deselect clears the link unless hold freezes it
  assign link_rst  = CS_N & HOLD_N;
  assign byte_done = (bit_cnt_reg == LAST_BIT) && HOLD_N;
  assign rx_byte   = {shift_reg, SI};

  always_comb begin
    status_byte             = SR_RESET;
    status_byte[SR_PPE_BIT] = ppe_reg;
    status_byte[SR_BP_HI:SR_BP_LO] = bp_reg;
    status_byte[SR_WEL_BIT] = wel_reg;
  end

  function automatic logic is_protected(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    case (bp)
      BP_QUARTER: hit = (a[ADDR_W-1:ADDR_W-2] == 2'h3);
      BP_HALF:    hit = a[ADDR_W-1];
      BP_ALL:     hit = 1'b1;
      default:    hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Write commits on the last data bit, no busy time
  assign wr_commit = (state_reg == ST_WRITE) && byte_done && wel_reg
                     && !is_protected(bp_reg, addr_reg);
  // Protect pin blocks status writes when enabled
  assign sr_commit = (state_reg == ST_STAT_WR) && byte_done && wel_reg
                     && !(ppe_reg && !wp_sync_reg);

  always_comb begin
    mem_re   = 1'b0;
    mem_addr = addr_reg;
    if ((state_reg == ST_ADDR) && byte_done && addr_byte_reg && read_cmd_reg) begin
      mem_re   = 1'b1;
      mem_addr = {addr_reg[7:0], rx_byte};
    end else if ((state_reg == ST_READ) && byte_done) begin
      mem_re   = 1'b1;
      mem_addr = addr_reg + 16'h0001;
    end
  end

  fram_array u_array (
    .clk   (SCK),
    .we    (wr_commit),
    .re    (mem_re),
    .addr  (mem_addr),
    .wdata (rx_byte),
    .rdata (mem_rdata)
  );

  // Link sequencer, no timeout, so a stopped SCK keeps state
  always_ff @(posedge SCK or posedge link_rst) begin
    if (link_rst) begin
      state_reg     <= ST_OPCODE;
      bit_cnt_reg   <= 3'h0;
      shift_reg     <= 7'h00;
      addr_reg      <= 16'h0000;
      addr_byte_reg <= 1'b0;
      read_cmd_reg  <= 1'b0;
      rose_reg      <= 1'b0;
    end else if (HOLD_N) begin
      // Hold low freezes every counter
      rose_reg    <= 1'b1;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg   <= rx_byte[6:0];
      if (byte_done) begin
        case (state_reg)
          ST_OPCODE: begin
            addr_reg      <= 16'h0000;
            addr_byte_reg <= 1'b0;
            case (rx_byte)
              OPC_READ: begin
                state_reg    <= ST_ADDR;
                read_cmd_reg <= 1'b1;
              end
              OPC_WRITE: begin
                state_reg    <= ST_ADDR;
                read_cmd_reg <= 1'b0;
              end
              OPC_STAT_RD: state_reg <= ST_STAT_RD;
              OPC_STAT_WR: state_reg <= ST_STAT_WR;
              OPC_ID_RD:   state_reg <= ST_ID;
              default:     state_reg <= ST_IGNORE;
            endcase
          end
          ST_ADDR: begin
            // Two address bytes, high byte first
            addr_reg      <= {addr_reg[7:0], rx_byte};
            addr_byte_reg <= 1'b1;
            if (addr_byte_reg) begin
              state_reg <= read_cmd_reg ? ST_READ : ST_WRITE;
            end
          end
          ST_WRITE: addr_reg <= addr_reg + 16'h0001;
          ST_READ:  addr_reg <= addr_reg + 16'h0001;
          ST_ID:    addr_reg <= addr_reg + 16'h0001;
          ST_STAT_WR: state_reg <= ST_IGNORE;
          default:  state_reg <= state_reg;
        endcase
      end
    end
  end

  // Status bits live across selections; deselect leaves them, only RESET_N or a command changes them
  always_ff @(posedge SCK or negedge RESET_N) begin
    if (!RESET_N) begin
      wel_reg <= 1'b0;
      bp_reg  <= BP_NONE;
      ppe_reg <= 1'b0;
    end else if ((state_reg == ST_OPCODE) && byte_done) begin
      if (rx_byte == OPC_WR_ENABLE) begin
        wel_reg <= 1'b1;
      end else if (rx_byte == OPC_WR_DISABLE) begin
        wel_reg <= 1'b0;
      end
    end else if (sr_commit) begin
      ppe_reg <= rx_byte[SR_PPE_BIT];
      bp_reg  <= rx_byte[SR_BP_HI:SR_BP_LO];
      wel_reg <= 1'b0;
    end
  end

  // Protect pin is not tied to SCK, so it is synchronised
  always_ff @(posedge SCK or negedge RESET_N) begin
    if (!RESET_N) begin
      wp_meta_reg <= 1'b1;
      wp_sync_reg <= 1'b1;
    end else begin
      wp_meta_reg <= WP_N;
      wp_sync_reg <= wp_meta_reg;
    end
  end

  always_comb begin
    case (state_reg)
      ST_READ:    tx_byte = mem_rdata;
      ST_STAT_RD: tx_byte = status_byte;
      ST_ID: begin
        case (addr_reg[1:0])
          2'h0:    tx_byte = ID_MAKER;
          2'h1:    tx_byte = ID_DENSITY;
          2'h2:    tx_byte = ID_REVISION;
          default: tx_byte = 8'h00;
        endcase
      end
      default:    tx_byte = 8'h00;
    endcase
  end

  // Only read states drive, so a shared data wire is safe
  assign tx_state = (state_reg == ST_READ) || (state_reg == ST_STAT_RD) || (state_reg == ST_ID);

  // Output shifter on falling edges
  always_ff @(negedge SCK or posedge link_rst) begin
    if (link_rst) begin
      so_reg       <= 1'b0;
      oe_n_reg     <= 1'b1;
      tx_shift_reg <= 7'h00;
      mode3_reg    <= 1'b0;
    end else if (HOLD_N) begin
      // A fall before any rise means SCK was high at select
      if (!rose_reg) begin
        mode3_reg <= 1'b1;
      end
      if (tx_state && rose_reg) begin
        oe_n_reg <= 1'b0;
        if (bit_cnt_reg == 3'h0) begin
          so_reg       <= tx_byte[7];
          tx_shift_reg <= tx_byte[6:0];
        end else begin
          so_reg       <= tx_shift_reg[6];
          tx_shift_reg <= {tx_shift_reg[5:0], 1'b0};
        end
      end else begin
        oe_n_reg <= 1'b1;
      end
    end
  end

  assign SO = so_reg;
  // Hold must float the pin at once, without an SCK edge
  assign SO_OE_N = oe_n_reg | ~HOLD_N;

  // Committed bytes cross by toggle handshake; data stands until acknowledged
  always_ff @(posedge SCK or negedge RESET_N) begin
    if (!RESET_N) begin
      req_reg      <= 1'b0;
      xfer_reg     <= '0;
      ovr_reg      <= 1'b0;
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
    end else begin
      ack_meta_reg <= ack_reg;
      ack_sync_reg <= ack_meta_reg;
      if (wr_commit) begin
        if (ack_sync_reg == req_reg) begin
          xfer_reg <= '{addr: addr_reg, data: rx_byte};
          req_reg  <= ~req_reg;
        end else begin
          // The array still takes the byte; only its notice is lost
          ovr_reg <= 1'b1;
        end
      end
    end
  end

  // Level synchronisers into the core clock
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      req_meta_reg  <= 1'b0;
      req_sync_reg  <= 1'b0;
      ovr_meta_reg  <= 1'b0;
      ovr_sync_reg  <= 1'b0;
      mode_meta_reg <= 1'b0;
      mode_sync_reg <= 1'b0;
      cs_meta_reg   <= 1'b1;
      cs_sync_reg   <= 1'b1;
    end else begin
      req_meta_reg  <= req_reg;
      req_sync_reg  <= req_meta_reg;
      ovr_meta_reg  <= ovr_reg;
      ovr_sync_reg  <= ovr_meta_reg;
      mode_meta_reg <= mode3_reg;
      mode_sync_reg <= mode_meta_reg;
      cs_meta_reg   <= CS_N;
      cs_sync_reg   <= cs_meta_reg;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      OVERRUN    <= 1'b0;
      LINK_MODE3 <= 1'b0;
      STANDBY    <= 1'b1;
    end else begin
      OVERRUN    <= ovr_sync_reg;
      LINK_MODE3 <= mode_sync_reg;
      STANDBY    <= cs_sync_reg;
    end
  end

  // A full buffer withholds the acknowledge, so the next commit waits in xfer_reg and commits after it raise the overrun flag
  assign buf_ready = ~spare_valid_reg;
  assign push      = (req_sync_reg != ack_reg) && buf_ready;
  assign pop       = out_valid_reg && WR_READY;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_reg <= 1'b0;
    end else if (push) begin
      ack_reg <= ~ack_reg;
    end
  end

  // Two-entry buffer: output stage plus one spare
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      out_reg         <= '0;
      out_valid_reg   <= 1'b0;
      spare_reg       <= '0;
      spare_valid_reg <= 1'b0;
    end else if (pop) begin
      out_reg         <= spare_valid_reg ? spare_reg : xfer_reg;
      out_valid_reg   <= spare_valid_reg | push;
      spare_valid_reg <= 1'b0;
    end else if (push) begin
      if (!out_valid_reg) begin
        out_reg       <= xfer_reg;
        out_valid_reg <= 1'b1;
      end else begin
        spare_reg       <= xfer_reg;
        spare_valid_reg <= 1'b1;
      end
    end
  end

  assign WR_WORD  = out_reg;
  assign WR_VALID = out_valid_reg;

endmodule

// [testbench/serial_fram_port_chk.sv]
// Concurrent checks on the pins and write stream of the serial F-RAM port.
// Assumes one master that keeps SCK still while deselected.
`timescale 1ns/1ps
module serial_fram_port_chk
  import serial_fram_pkg::*;
(
  input wire logic                            CORE_CLK,
  input wire logic                            RESET_N,
  input wire logic                            SCK,
  input wire logic                            CS_N,
  input wire logic                            SI,
  input wire logic                            SO,
  input wire logic                            SO_OE_N,
  input wire logic                            HOLD_N,
  input wire serial_fram_pkg::write_word_type WR_WORD,
  input wire logic                            WR_VALID,
  input wire logic                            WR_READY,
  input wire logic                            OVERRUN,
  input wire logic                            STANDBY
);
  logic [3:0] bits_seen;
  logic [7:0] op_seen;

  // Own opcode tracker; saturates so data bits never disturb the opcode
  always_ff @(posedge SCK or posedge CS_N) begin
    if (CS_N) begin
      bits_seen <= 4'h0;
      op_seen   <= 8'h00;
    end else if (HOLD_N && bits_seen < 4'h8) begin
      bits_seen <= bits_seen + 4'h1;
      op_seen   <= {op_seen[6:0], SI};
    end
  end

  property p_oe_deselected;
    @(posedge CORE_CLK) disable iff (!RESET_N) CS_N && $past(CS_N) |-> SO_OE_N;
  endproperty
  a_oe_deselected: assert property (p_oe_deselected) else $error("output driven while deselected");

  property p_standby;
    @(posedge CORE_CLK) disable iff (!RESET_N) CS_N [*4] |-> STANDBY;
  endproperty
  a_standby: assert property (p_standby) else $error("standby flag late");

  property p_oe_hold;
    @(posedge CORE_CLK) disable iff (!RESET_N) !HOLD_N |-> SO_OE_N;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("output driven during hold");

  property p_so_fall_only;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      SCK && $past(SCK) && !CS_N && $past(!CS_N) |-> $stable(SO);
  endproperty
  a_so_fall_only: assert property (p_so_fall_only) else $error("output moved while SCK high");

  property p_cmd_quiet;
    @(posedge SCK) disable iff (CS_N)
      bits_seen < 4'h8 || (op_seen != OPC_STAT_RD && op_seen != OPC_ID_RD && op_seen != OPC_READ)
      |-> SO_OE_N;
  endproperty
  a_cmd_quiet: assert property (p_cmd_quiet) else $error("output driven on input phase");

  property p_read_drive;
    @(posedge SCK) disable iff (CS_N)
      bits_seen == 4'h8 && HOLD_N && (op_seen == OPC_STAT_RD || op_seen == OPC_ID_RD) |-> !SO_OE_N;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read data not driven");

  property p_word_holds;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      WR_VALID && !WR_READY |=> WR_VALID && $stable(WR_WORD);
  endproperty
  a_word_holds: assert property (p_word_holds) else $error("stalled word lost");

  property p_overrun_sticky;
    @(posedge CORE_CLK) disable iff (!RESET_N) OVERRUN |=> OVERRUN;
  endproperty
  a_overrun_sticky: assert property (p_overrun_sticky) else $error("overrun flag cleared");
endmodule

bind serial_fram_port serial_fram_port_chk u_chk (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .SCK(SCK), .CS_N(CS_N), .SI(SI), .SO(SO),
  .SO_OE_N(SO_OE_N), .HOLD_N(HOLD_N), .WR_WORD(WR_WORD), .WR_VALID(WR_VALID),
  .WR_READY(WR_READY), .OVERRUN(OVERRUN), .STANDBY(STANDBY));

// [testbench/spi_master_model.sv]
// Behavioural SPI master driving the F-RAM port pins, 30 ns SCK period.
// Assumes the caller runs one transfer at a time.
`timescale 1ns/1ps
module spi_master_model (
  output logic     sck,
  output logic     cs_n,
  output logic     si,
  output logic     hold_n,
  input wire logic so,
  input wire logic so_oe_n
);
  localparam time HALF = 15ns;
  logic mode3;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
    mode3 = 1'b0;
  end

  // Idle clock level picks the mode before the select edge
  task automatic sel(input logic m3);
    mode3 = m3;
    sck = m3;
    #HALF;
    cs_n = 1'b0;
    #HALF;
  endtask

  // Clock stands still between bytes; MSB goes first
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 8 - nb; i--) begin
      sck = 1'b0;
      si = tx[i];
      #HALF;
      sck = 1'b1;
      // A floating pin reads as the inverse, so a late enable shows up
      rx[i] = so_oe_n ? ~so : so;
      #HALF;
    end
  endtask

  task automatic desel();
    sck = mode3;
    #HALF;
    cs_n = 1'b1;
    si = ~si; // Released line shows no stale bit
    #(2 * HALF);
  endtask

  task automatic hold(input logic lvl);
    sck = 1'b0;
    #HALF;
    hold_n = lvl;
    #(2 * HALF);
  endtask
endmodule

// [testbench/serial_fram_spi_slave_port_tb_top.sv]
// Self-checking bench for the serial F-RAM port with a behavioural master.
// Assumes the checker is bound onto the port.
`timescale 1ns/1ps
module serial_fram_spi_slave_port_tb_top;
  import serial_fram_pkg::*;
  typedef struct packed {logic m3; logic [15:0] a; logic [7:0] d;} row_type;
  logic           core_clk = 1'b0;
  logic           reset_n  = 1'b0;
  logic           wp_n     = 1'b1;
  logic           wr_ready = 1'b1;
  logic           sck, cs_n, si, hold_n, so, so_oe_n, wr_valid, overrun, standby, link_mode3;
  write_word_type wr_word, w;
  write_word_type wq[$];
  logic [7:0]     rb;
  int             failures = 0;
  int             n_compared = 0;
  int             cyc = 0;
  row_type rows [4] = '{'{1'b0, 16'h0000, 8'hA5}, '{1'b1, 16'hFFFF, 8'h3C},
                        '{1'b0, 16'h8000, 8'h01}, '{1'b1, 16'h1234, 8'hFE}};

  always #4 core_clk = ~core_clk;

  spi_master_model m (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so),
    .so_oe_n(so_oe_n));

  serial_fram_port dut (.CORE_CLK(core_clk), .RESET_N(reset_n), .SCK(sck), .CS_N(cs_n),
    .SI(si), .SO(so), .SO_OE_N(so_oe_n), .WP_N(wp_n), .HOLD_N(hold_n), .WR_WORD(wr_word),
    .WR_VALID(wr_valid), .WR_READY(wr_ready), .OVERRUN(overrun), .STANDBY(standby),
    .LINK_MODE3(link_mode3));

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (reset_n && wr_valid && wr_ready) wq.push_back(wr_word);
    if (cyc == 60000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({23'h0, got}, {23'h0, exp});
  endtask

  task automatic start(input logic m3, input logic [7:0] op, input logic [15:0] a, input int na);
    m.sel(m3);
    m.xfer(op, 8, rb);
    if (na > 0) m.xfer(a[15:8], 8, rb);
    if (na > 0) m.xfer(a[7:0], 8, rb);
  endtask

  task automatic op2(input logic [7:0] op, input logic [7:0] d, input int nd);
    start(1'b0, op, 16'h0000, 0);
    if (nd > 0) m.xfer(d, 8, rb);
    m.desel();
  endtask

  task automatic wr(input logic m3, input logic [15:0] a, input logic [7:0] d);
    start(m3, OPC_WRITE, a, 2);
    m.xfer(d, 8, rb);
    m.desel();
  endtask

  task automatic rd(input logic m3, input logic [15:0] a, output logic [7:0] d);
    start(m3, OPC_READ, a, 2);
    m.xfer(8'h00, 8, d);
    m.desel();
  endtask

  task automatic pop(output write_word_type x);
    int n;
    n = 0;
    while (wq.size() == 0 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    x = (wq.size() == 0) ? 'x : wq.pop_front();
  endtask

  initial begin
    repeat (8) @(negedge core_clk);
    reset_n = 1'b1;
    @(negedge core_clk);
    chk_bit(standby, 1'b1);
    chk_bit(so_oe_n, 1'b1);
    chk_bit(wr_valid, 1'b0);
    $display("test reset done");
    foreach (rows[i]) begin
      op2(OPC_WR_ENABLE, 8'h00, 0);
      wq.delete();
      wr(rows[i].m3, rows[i].a, rows[i].d);
      pop(w);
      chk_val(w, {rows[i].a, rows[i].d});
      start(rows[i].m3, OPC_READ, rows[i].a, 2);
      m.xfer(8'h00, 8, rb);
      // Mode flag and standby are only meaningful while still selected
      repeat (4) @(negedge core_clk);
      chk_bit(link_mode3, rows[i].m3);
      chk_bit(standby, 1'b0);
      m.desel();
      chk_val(rb, rows[i].d);
    end
    rd(1'b0, 16'h0000, rb);
    chk_val(rb, 8'hA5);
    $display("test table done");
    start(1'b0, OPC_ID_RD, 16'h0000, 0);
    m.xfer(8'h00, 8, rb);
    chk_val(rb, ID_MAKER);
    m.xfer(8'h00, 8, rb);
    chk_val(rb, ID_DENSITY);
    m.xfer(8'h00, 8, rb);
    chk_val(rb, ID_REVISION);
    m.desel();
    op2(OPC_STAT_RD, 8'h00, 1);
    chk_val(rb, 8'h02);
    op2(OPC_WR_DISABLE, 8'h00, 0);
    wr(1'b0, 16'h0000, 8'h77);
    rd(1'b0, 16'h0000, rb);
    chk_val(rb, 8'hA5);
    op2(OPC_WR_ENABLE, 8'h00, 0);
    op2(OPC_STAT_WR, 8'h84, 1);
    op2(OPC_STAT_RD, 8'h00, 1);
    chk_val(rb, 8'h84);
    op2(OPC_WR_ENABLE, 8'h00, 0);
    wr(1'b0, 16'hFFFF, 8'h11);
    rd(1'b0, 16'hFFFF, rb);
    chk_val(rb, 8'h3C);
    $display("test protect done");
    @(negedge core_clk) wp_n = 1'b0;
    op2(OPC_STAT_WR, 8'h00, 1);
    op2(OPC_STAT_RD, 8'h00, 1);
    chk_val(rb, 8'h86);
    @(negedge core_clk) wp_n = 1'b1;
    op2(OPC_STAT_WR, 8'h00, 1);
    op2(OPC_STAT_RD, 8'h00, 1);
    chk_val(rb, 8'h00);
    start(1'b0, 8'hAA, 16'h0000, 0);
    m.xfer(8'h00, 8, rb);
    chk_bit(so_oe_n, 1'b1);
    m.desel();
    op2(OPC_WR_ENABLE, 8'h00, 0);
    start(1'b0, OPC_WRITE, 16'h1234, 2);
    m.xfer(8'h00, 4, rb);
    m.desel();
    rd(1'b0, 16'h1234, rb);
    chk_val(rb, 8'hFE);
    start(1'b0, OPC_READ, 16'hFFFF, 2);
    m.xfer(8'h00, 8, rb);
    chk_val(rb, 8'h3C);
    m.hold(1'b0);
    chk_bit(so_oe_n, 1'b1);
    m.hold(1'b1);
    m.xfer(8'h00, 8, rb);
    chk_val(rb, 8'hA5);
    m.desel();
    $display("test hold done");
    @(negedge core_clk) wr_ready = 1'b0;
    op2(OPC_WR_ENABLE, 8'h00, 0);
    start(1'b0, OPC_WRITE, 16'h2000, 2);
    for (int i = 0; i < 4; i++) m.xfer(8'h10 + 8'(i), 8, rb);
    m.desel();
    repeat (10) @(negedge core_clk);
    chk_bit(overrun, 1'b1);
    chk_bit(wr_valid, 1'b1);
    wq.delete();
    wr_ready = 1'b1;
    pop(w);
    chk_val(w, {16'h2000, 8'h10});
    pop(w);
    chk_val(w, {16'h2001, 8'h11});
    rd(1'b0, 16'h2003, rb);
    chk_val(rb, 8'h13);
    $display("test stall done");
    @(negedge core_clk) reset_n = 1'b0;
    repeat (2) @(negedge core_clk);
    chk_bit(overrun, 1'b0);
    reset_n = 1'b1;
    @(negedge core_clk);
    chk_bit(wr_valid, 1'b0);
    chk_bit(standby, 1'b1);
    op2(OPC_STAT_RD, 8'h00, 1);
    chk_val(rb, 8'h00);
    $display("test midrun reset done");
    tally_and_finish();
  end
endmodule
